//--- obh_pkg.sv
`default_nettype none
package obh_pkg;
   localparam int unsigned ADDR_BITS    = 4;
   localparam int unsigned DATA_BITS    = 8;
   localparam int unsigned RAM_DEPTH    = 16;
   localparam logic [3:0]  CMD_TO_CLOCK = 4'he;
   localparam logic [3:0]  CMD_TO_RAM   = 4'hf;
   localparam logic [2:0]  LAST_ADDR    = 3'h3;
   localparam logic [2:0]  LAST_DATA    = 3'h7;
   localparam logic [7:0]  RAM_RESET    = 8'h00;

   typedef enum logic {MODE_STROBE_PAIR, MODE_DATA_STROBE} obh_mode_e;
   typedef enum logic {PH_ADDR, PH_DATA} obh_phase_e;

   // one completed cycle handed to the clock core
   typedef struct packed {
      logic       isCmd;
      logic [3:0] addr;
      logic [7:0] data;
   } obh_upd_s;
endpackage : obh_pkg
`default_nettype wire

//--- obh_host_port.sv
// Overview of operation
// - only chip-selected accesses are served
// - strobe pair: one read/write strobe, one bit
// - data strobe qualifies access, direction picks read/write
// - strobe tied to select: select times access
// - every bit passes one two-way data pin
// - cycle opens with four written address bits
// - eight data bits, lsb first, end cycle
// - codes e/f end cycle, run command
`timescale 1ns/1ns
`default_nettype none
module obh_host_port (
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   input  wire obh_pkg::obh_mode_e  busMode,
   input  wire logic                chip_sel_n,
   input  wire logic                data_strobe_n,
   input  wire logic                rw_strobe,
   input  wire logic                ioIn,
   output var  logic                ioOut,
   output var  logic                ioOe,
   input  wire logic                coreWe,
   input  wire logic [3:0]          coreAddr,
   input  wire logic [7:0]          coreData,
   output var  obh_pkg::obh_upd_s   updData,
   output var  logic                updValid,
   input  wire logic                updReady,
   output var  logic                busy
);
   //----------------------------------------------------------------
   // access detection
   //----------------------------------------------------------------
   function automatic logic is_cmd(input logic [3:0] a);
      is_cmd = (a == obh_pkg::CMD_TO_CLOCK) || (a == obh_pkg::CMD_TO_RAM);
   endfunction : is_cmd

   logic                actNow;
   logic                rdNow;
   logic                accStart;
   logic                accEnd;
   logic                actPrev_r, actPrev_nxt;
   logic                acc_r,     acc_nxt;
   logic                accRd_r,   accRd_nxt;
   logic                ioLast_r,  ioLast_nxt;
   logic                ioOut_r,   ioOut_nxt;
   logic                ioOe_r,    ioOe_nxt;
   obh_pkg::obh_phase_e phase_r,   phase_nxt;
   logic [2:0]          bitCnt_r,  bitCnt_nxt;
   logic [3:0]          addr_r,    addr_nxt;
   logic [7:0]          dataSh_r,  dataSh_nxt;
   logic                pend_r,    pend_nxt;
   obh_pkg::obh_upd_s   pendUpd_r, pendUpd_nxt;
   logic                updValid_r, updValid_nxt;
   logic                fifoV1_r,   fifoV1_nxt;
   logic                ramWe;
   logic [3:0]          ramWa;
   logic [7:0]          ramWd;
   logic [7:0]          ram [obh_pkg::RAM_DEPTH];
   logic [3:0]          fullAddr;

   always_comb begin
      if (busMode == obh_pkg::MODE_STROBE_PAIR) begin
         actNow = !chip_sel_n && (!data_strobe_n || !rw_strobe);
         rdNow  = !data_strobe_n;
      end else begin
         // with the strobe tied to select, select alone times it
         actNow = !chip_sel_n && !data_strobe_n;
         rdNow  = rw_strobe;
      end
   end

   // a new access is held off while a finished cycle waits for the buffer
   assign accStart = actNow && !actPrev_r && !pend_r;
   assign accEnd   = !actNow && acc_r;
   assign fullAddr = {ioLast_r, addr_r[3:1]};

   //----------------------------------------------------------------
   // bit sequencer
   //----------------------------------------------------------------
   always_comb begin
      actPrev_nxt = actNow;
      acc_nxt     = acc_r;
      accRd_nxt   = accRd_r;
      ioLast_nxt  = actNow ? ioIn : ioLast_r;
      ioOut_nxt   = ioOut_r;
      ioOe_nxt    = ioOe_r;
      phase_nxt   = phase_r;
      bitCnt_nxt  = bitCnt_r;
      addr_nxt    = addr_r;
      dataSh_nxt  = dataSh_r;
      pend_nxt    = pend_r;
      pendUpd_nxt = pendUpd_r;
      ramWe       = coreWe;
      ramWa       = coreAddr;
      ramWd       = coreData;
      if (pend_r && !(updValid_r && fifoV1_r && !updReady)) begin
         pend_nxt = 1'b0;
      end
      if (accStart) begin
         acc_nxt   = 1'b1;
         accRd_nxt = rdNow;
         if (rdNow) begin
            ioOe_nxt = 1'b1;
            if (phase_r == obh_pkg::PH_ADDR) begin
               // reads never open a cycle; they rewind the address
               bitCnt_nxt = 3'h0;
            end else begin
               ioOut_nxt = ram[addr_r][bitCnt_r];
               if (bitCnt_r == obh_pkg::LAST_DATA) begin
                  phase_nxt  = obh_pkg::PH_ADDR;
                  bitCnt_nxt = 3'h0;
               end else begin
                  bitCnt_nxt = bitCnt_r + 3'h1;
               end
            end
         end
      end else if (accEnd) begin
         acc_nxt  = 1'b0;
         ioOe_nxt = 1'b0;
         if (!accRd_r) begin
            if (phase_r == obh_pkg::PH_ADDR) begin
               addr_nxt = fullAddr;
               if (bitCnt_r != obh_pkg::LAST_ADDR) begin
                  bitCnt_nxt = bitCnt_r + 3'h1;
               end else if (is_cmd(fullAddr)) begin
                  bitCnt_nxt  = 3'h0;
                  pend_nxt    = 1'b1;
                  pendUpd_nxt = '{isCmd: 1'b1, addr: fullAddr, data: 8'h00};
               end else begin
                  bitCnt_nxt = 3'h0;
                  phase_nxt  = obh_pkg::PH_DATA;
               end
            end else begin
               dataSh_nxt = {ioLast_r, dataSh_r[7:1]};
               if (bitCnt_r == obh_pkg::LAST_DATA) begin
                  phase_nxt   = obh_pkg::PH_ADDR;
                  bitCnt_nxt  = 3'h0;
                  ramWe       = 1'b1;
                  ramWa       = addr_r;
                  ramWd       = dataSh_nxt;
                  pend_nxt    = 1'b1;
                  pendUpd_nxt = '{isCmd: 1'b0, addr: addr_r, data: dataSh_nxt};
               end else begin
                  bitCnt_nxt = bitCnt_r + 3'h1;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         actPrev_r <= 1'b0;
         acc_r     <= 1'b0;
         accRd_r   <= 1'b0;
         ioLast_r  <= 1'b0;
         ioOut_r   <= 1'b0;
         ioOe_r    <= 1'b0;
         phase_r   <= obh_pkg::PH_ADDR;
         bitCnt_r  <= 3'h0;
         addr_r    <= 4'h0;
         dataSh_r  <= 8'h00;
         pend_r    <= 1'b0;
         pendUpd_r <= '0;
      end else begin
         actPrev_r <= actPrev_nxt;
         acc_r     <= acc_nxt;
         accRd_r   <= accRd_nxt;
         ioLast_r  <= ioLast_nxt;
         ioOut_r   <= ioOut_nxt;
         ioOe_r    <= ioOe_nxt;
         phase_r   <= phase_nxt;
         bitCnt_r  <= bitCnt_nxt;
         addr_r    <= addr_nxt;
         dataSh_r  <= dataSh_nxt;
         pend_r    <= pend_nxt;
         pendUpd_r <= pendUpd_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < obh_pkg::RAM_DEPTH; i++) begin
            ram[i] <= obh_pkg::RAM_RESET;
         end
      end else if (ramWe) begin
         ram[ramWa] <= ramWd;
      end
   end

   //----------------------------------------------------------------
   // two-entry buffer toward the clock core
   //----------------------------------------------------------------
   obh_pkg::obh_upd_s fifo0_r,    fifo0_nxt;
   obh_pkg::obh_upd_s fifo1_r,    fifo1_nxt;
   logic              push;
   logic              pop;

   assign pop  = updValid_r && updReady;
   assign push = pend_r && !pend_nxt;

   always_comb begin
      updValid_nxt = updValid_r;
      fifoV1_nxt   = fifoV1_r;
      fifo0_nxt    = fifo0_r;
      fifo1_nxt    = fifo1_r;
      if (pop) begin
         updValid_nxt = fifoV1_r;
         fifo0_nxt    = fifo1_r;
         fifoV1_nxt   = 1'b0;
      end
      if (push) begin
         if (!updValid_nxt) begin
            updValid_nxt = 1'b1;
            fifo0_nxt    = pendUpd_r;
         end else begin
            fifoV1_nxt = 1'b1;
            fifo1_nxt  = pendUpd_r;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         updValid_r <= 1'b0;
         fifoV1_r   <= 1'b0;
         fifo0_r    <= '0;
         fifo1_r    <= '0;
      end else begin
         updValid_r <= updValid_nxt;
         fifoV1_r   <= fifoV1_nxt;
         fifo0_r    <= fifo0_nxt;
         fifo1_r    <= fifo1_nxt;
      end
   end

   assign ioOut    = ioOut_r;
   assign ioOe     = ioOe_r;
   assign updData  = fifo0_r;
   assign updValid = updValid_r;
   assign busy     = pend_r;

   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_select_gates_drive: assert property (chip_sel_n |=> !ioOe)
      else $error("data pin driven while deselected");
   a_pair_read_bit: assert property (
      busMode == obh_pkg::MODE_STROBE_PAIR && accStart && !data_strobe_n |=> ioOe && accRd_r)
      else $error("strobe pair read not driven");
   a_ds_read_dir: assert property (
      busMode == obh_pkg::MODE_DATA_STROBE && accStart && rw_strobe |=> ioOe)
      else $error("direction high did not start a read");
   a_ds_write_dir: assert property (
      busMode == obh_pkg::MODE_DATA_STROBE && accStart && !rw_strobe |=> !ioOe && !accRd_r)
      else $error("direction low did not start a write");
   a_pin_bit_stable: assert property (ioOe && $past(ioOe) |-> $stable(ioOut))
      else $error("read bit changed during access");
   a_drive_read_only: assert property (ioOe |-> acc_r && accRd_r)
      else $error("data pin driven outside a read");
   a_read_no_start: assert property (
      accStart && rdNow && phase_r == obh_pkg::PH_ADDR |=> phase_r == obh_pkg::PH_ADDR && bitCnt_r == 3'h0)
      else $error("read advanced the address phase");
   a_byte_end: assert property (
      accEnd && !accRd_r && phase_r == obh_pkg::PH_DATA && bitCnt_r == obh_pkg::LAST_DATA
      |=> phase_r == obh_pkg::PH_ADDR && bitCnt_r == 3'h0 && pend_r)
      else $error("cycle did not end on eighth data bit");
   a_cmd_end: assert property (
      accEnd && !accRd_r && phase_r == obh_pkg::PH_ADDR && bitCnt_r == obh_pkg::LAST_ADDR
      && is_cmd(fullAddr) |=> phase_r == obh_pkg::PH_ADDR && bitCnt_r == 3'h0 && pendUpd_r.isCmd
      ##[1:8] updValid)
      else $error("command cycle mishandled");

   c_command: cover property (push && pendUpd_r.isCmd);
   c_write_byte: cover property (push && !pendUpd_r.isCmd);
   c_read_byte: cover property (accStart && rdNow && phase_r == obh_pkg::PH_DATA && bitCnt_r == obh_pkg::LAST_DATA);
   c_buffer_full: cover property (updValid && fifoV1_r && pend_r);
endmodule : obh_host_port
`default_nettype wire

//--- obh_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------
// host cpu model: one bit per access over one shared data pin
// ----------
module obh_host_model (
   input  wire logic               core_clk,
   input  wire obh_pkg::obh_mode_e busMode,
   input  wire logic               tieMode,
   input  wire logic               ioOut,
   input  wire logic               ioOe,
   output var  logic               chip_sel_n,
   output var  logic               data_strobe_n,
   output var  logic               rw_strobe,
   output wire logic               ioIn
);
   logic drv  = 1'b0;
   logic bitV = 1'b0;
   logic idle = 1'b0;
   initial begin
      chip_sel_n    = 1'b1;
      data_strobe_n = 1'b1;
      rw_strobe     = 1'b1;
   end
   always @(posedge core_clk) idle <= ~idle;
   // a released pin shows a toggling level, never the last bit
   assign ioIn = ioOe ? ioOut : (drv ? bitV : idle);
   task automatic access(input logic rd, input logic wb, input logic sel, output logic rb, output logic oe);
      @(posedge core_clk);
      chip_sel_n    <= ~sel;
      data_strobe_n <= (busMode == obh_pkg::MODE_STROBE_PAIR) ? ~rd : (tieMode ? ~sel : 1'b0);
      rw_strobe     <= rd;
      drv           <= ~rd;
      bitV          <= wb;
      repeat (3) @(posedge core_clk);
      rb = ioIn;
      oe = ioOe;
      chip_sel_n    <= 1'b1;
      data_strobe_n <= 1'b1;
      rw_strobe     <= 1'b1;
      drv           <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : access
endmodule : obh_host_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic               core_clk, rst_n, tieMode, coreWe, updReady;
   obh_pkg::obh_mode_e busMode;
   logic [3:0]         coreAddr;
   logic [7:0]         coreData;
   wire                chip_sel_n, data_strobe_n, rw_strobe, ioIn;
   logic               ioOut, ioOe, updValid, busy;
   obh_pkg::obh_upd_s  updData;
   obh_pkg::obh_upd_s  q[$];
   int                 mismatches = 0;
   int                 checks = 0;
   int                 cycles = 0;
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   obh_host_port dut (.core_clk(core_clk), .rst_n(rst_n), .busMode(busMode), .chip_sel_n(chip_sel_n),
      .data_strobe_n(data_strobe_n), .rw_strobe(rw_strobe), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
      .coreWe(coreWe), .coreAddr(coreAddr), .coreData(coreData), .updData(updData), .updValid(updValid),
      .updReady(updReady), .busy(busy));
   obh_host_model host (.core_clk(core_clk), .busMode(busMode), .tieMode(tieMode), .ioOut(ioOut),
      .ioOe(ioOe), .chip_sel_n(chip_sel_n), .data_strobe_n(data_strobe_n), .rw_strobe(rw_strobe), .ioIn(ioIn));
   // ----------
   // shared tasks
   // ----------
   task automatic report_and_stop;
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (updValid === 1'b1 && updReady === 1'b1) q.push_back(updData);
      if (cycles == 30000) begin
         mismatches++;
         report_and_stop();
      end
   end
   task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic bit_io(input logic rd, input logic wb, output logic rb);
      logic oe;
      host.access(rd, wb, 1'b1, rb, oe);
      check("ioOe", 13'(oe), 13'(rd));
   endtask : bit_io
   task automatic put_addr(input logic [3:0] a);
      logic r;
      for (int i = 0; i < 4; i++) bit_io(1'b0, a[i], r);
   endtask : put_addr
   task automatic wr_byte(input logic [3:0] a, input logic [7:0] d);
      logic r;
      put_addr(a);
      for (int i = 0; i < 8; i++) bit_io(1'b0, d[i], r);
   endtask : wr_byte
   task automatic rd_byte(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] got;
      put_addr(a);
      for (int i = 0; i < 8; i++) bit_io(1'b1, 1'b0, got[i]);
      check("read byte", 13'(got), 13'(d));
   endtask : rd_byte
   task automatic take(input logic [12:0] exp, input logic cmd);
      logic [12:0] s;
      for (int i = 0; i < 20 && q.size() == 0; i++) @(posedge core_clk);
      if (q.size() == 0) check("updValid", 13'h0000, 13'h0001);
      else begin
         s = q.pop_front();
         if (cmd) s[7:0] = 8'h00;
         check("updData", s, exp);
      end
   endtask : take
   // ----------
   // scenarios
   // ----------
   task automatic t_nosel;
      logic r, oe;
      q.delete();
      for (int i = 0; i < 8; i++) begin
         host.access(i[0], 1'b1, 1'b0, r, oe);
         check("ioOe", 13'(oe), 13'h0000);
      end
      wr_byte(4'h6, 8'h96);
      take({1'b0, 4'h6, 8'h96}, 1'b0);
   endtask : t_nosel
   task automatic t_cmd;
      logic [3:0] c;
      for (int i = 0; i < 2; i++) begin
         c = i[0] ? obh_pkg::CMD_TO_RAM : obh_pkg::CMD_TO_CLOCK;
         q.delete();
         put_addr(c);
         take({1'b1, c, 8'h00}, 1'b1);
         wr_byte(4'h9, 8'h3c);
         take({1'b0, 4'h9, 8'h3c}, 1'b0);
      end
   endtask : t_cmd
   task automatic t_core;
      coreWe   <= 1'b1;
      coreAddr <= 4'h8;
      coreData <= 8'hc3;
      @(posedge core_clk);
      coreWe <= 1'b0;
      rd_byte(4'h8, 8'hc3);
   endtask : t_core
   task automatic t_buffer;
      updReady <= 1'b0;
      q.delete();
      for (int i = 0; i < 3; i++) wr_byte(4'(i), 8'h11 * 8'(i + 1));
      repeat (3) @(posedge core_clk);
      check("busy", 13'(busy), 13'h0001);
      updReady <= 1'b1;
      for (int i = 0; i < 3; i++) take({1'b0, 4'(i), 8'h11 * 8'(i + 1)}, 1'b0);
      repeat (3) @(posedge core_clk);
      check("busy", 13'(busy), 13'h0000);
   endtask : t_buffer
   task automatic t_modes;
      logic r;
      for (int m = 0; m < 3; m++) begin
         busMode <= obh_pkg::obh_mode_e'(m != 0);
         tieMode <= (m == 2);
         @(posedge core_clk);
         // a partial address first, so the resync reads must rewind it
         for (int i = 0; i <= m; i++) bit_io(1'b0, 1'b1, r);
         for (int i = 0; i < 8; i++) bit_io(1'b1, 1'b0, r);
         q.delete();
         wr_byte(4'(m + 2), 8'ha5 ^ 8'(m));
         take({1'b0, 4'(m + 2), 8'ha5 ^ 8'(m)}, 1'b0);
         rd_byte(4'(m + 2), 8'ha5 ^ 8'(m));
      end
   endtask : t_modes
   initial begin
      rst_n    = 1'b0;
      busMode  = obh_pkg::MODE_STROBE_PAIR;
      tieMode  = 1'b0;
      coreWe   = 1'b0;
      coreAddr = 4'h0;
      coreData = 8'h00;
      updReady = 1'b1;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_nosel();
      t_cmd();
      t_core();
      t_buffer();
      t_modes();
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
